// file: rtl/rcc_map.svh
// register map, field positions, reset values and timing for rcc
`ifndef RCC_MAP_SVH
`define RCC_MAP_SVH
`define RCC_ADDR_W          8
`define RCC_OFS_CTRL        8'h00
`define RCC_OFS_MODEM       8'h04
`define RCC_OFS_LEVEL       8'h08
`define RCC_OFS_SYNTH       8'h0c
`define RCC_OFS_TRANSMIT_CONTROL_REG      8'h10
`define RCC_OFS_PINCFG      8'h14
`define RCC_OFS_STATUS      8'h18
`define RCC_OFS_CORR        8'h1c
`define RCC_CTRL_RX         0
`define RCC_CTRL_TX         1
`define RCC_CTRL_TXCLEAR    2
`define RCC_CTRL_OFF        3
`define RCC_MODEM_APPEND    0
`define RCC_MODEM_MODE_LO   1
`define RCC_MODEM_HYST_LO   3
`define RCC_ST_LVALID       0
`define RCC_ST_TXACT        1
`define RCC_ST_CAL          2
`define RCC_ST_CCA          3
`define RCC_ST_RXON         4
`define RCC_RST_MODEM       8'h2f
`define RCC_RST_THR         8'he0
`define RCC_RST_CHAN        10'h165
`define RCC_RST_TRANSMIT_CONTROL_REG      16'ha0ff
`define RCC_CARRIER_BASE    12'h800
`define RCC_IF_OFFSET       12'h002
`define RCC_RESP_OKAY       2'h0
`define RCC_RESP_SLVERR     2'h2
`define RCC_CLK_PERIOD_NS   25
`define RCC_SYMBOL_NS       16000
`define RCC_AVG_SYMBOLS     8
`define RCC_CAL_NS          192000
`endif

// file: rtl/rcc_pkg.sv
// types shared by the rcc design
package rcc_pkg;
    typedef enum logic [2:0] {
        RCC_IDLE, RCC_RX_CAL, RCC_RX, RCC_TX_CAL, RCC_ACK_CAL, RCC_TX
    } rcc_state_t;
    typedef struct packed {
        logic              sfdSeen;
        logic              frameActive;
        logic              frameEnd;
        logic              crcOk;
        logic              ackRequest;
        logic              txDone;
        logic signed [7:0] level;
        logic [6:0]        corr;
    } rcc_rx_in_t;
    typedef struct packed {
        logic [6:0]        corr;
        logic signed [7:0] level;
        logic              crcOk;
    } rcc_append_t;
endpackage : rcc_pkg

// file: rtl/rcc_level_avg.sv
// moving average of signal level over the latest symbols
`timescale 1ns/1ps
module rcc_level_avg #(
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              reset_n,
    // control
    input  wire logic              enable,
    input  wire logic              symTick,
    input  wire logic signed [7:0] sampleIn,
    // result
    output logic signed [7:0]      levelAvg,
    output logic                   levelValid
);
    localparam int SHIFT = $clog2(DEPTH);
    localparam int SUM_W = 8 + SHIFT;
    localparam int CNT_W = $clog2(DEPTH + 1);

    if (DEPTH < 2 || (1 << SHIFT) != DEPTH) begin : g_chk
        $error("rcc_level_avg: DEPTH must be a power of two");
    end

    logic signed [7:0]       histReg [DEPTH-1];
    logic [CNT_W-1:0]        fillReg;
    logic signed [SUM_W-1:0] sumNext;

    for (genvar i = 0; i < DEPTH - 1; i++) begin : g_hist
        logic signed [7:0] shiftIn;
        if (i == 0) begin : g_head
            assign shiftIn = sampleIn;
        end else begin : g_tail
            assign shiftIn = histReg[i-1];
        end
        always_ff @(posedge mclk) begin
            if (!reset_n || !enable) begin
                histReg[i] <= 8'sh00;
            end else if (symTick) begin
                histReg[i] <= shiftIn;
            end
        end
    end

    always_comb begin
        sumNext = SUM_W'(sampleIn);
        for (int i = 0; i < DEPTH - 1; i++) begin
            sumNext = sumNext + SUM_W'(histReg[i]);
        end
    end

    // average of the newest samples
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            levelAvg <= 8'sh00;
        end else if (enable && symTick) begin
            levelAvg <= 8'(sumNext >>> SHIFT);
        end
    end

    // valid after a full window of enabled symbols
    always_ff @(posedge mclk) begin
        if (!reset_n || !enable) begin
            fillReg    <= '0;
            levelValid <= 1'b0;
        end else if (symTick && fillReg != CNT_W'(DEPTH)) begin
            fillReg    <= fillReg + 1'b1;
            levelValid <= (fillReg == CNT_W'(DEPTH - 1));
        end
    end
endmodule : rcc_level_avg

// file: rtl/rcc_corr_avg.sv
// average correlation over the first symbols after frame start
`timescale 1ns/1ps
module rcc_corr_avg #(
    parameter int SYMBOLS = 8
) (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       reset_n,
    // input
    input  wire logic       start,
    input  wire logic       symTick,
    input  wire logic [6:0] corrIn,
    // result
    output logic [6:0]      corrAvg,
    output logic            corrDone
);
    localparam int SHIFT = $clog2(SYMBOLS);
    localparam int ACC_W = 7 + SHIFT;
    localparam int CNT_W = $clog2(SYMBOLS + 1);

    if (SYMBOLS < 2 || (1 << SHIFT) != SYMBOLS) begin : g_chk
        $error("rcc_corr_avg: SYMBOLS must be a power of two");
    end

    logic [ACC_W-1:0] accReg;
    logic [CNT_W-1:0] cntReg;
    logic             busyReg;
    logic [ACC_W-1:0] accNext;

    assign accNext = accReg + ACC_W'(corrIn);

    // unsigned mean of the first symbols of each packet
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            accReg   <= '0;
            cntReg   <= '0;
            busyReg  <= 1'b0;
            corrAvg  <= 7'h00;
            corrDone <= 1'b0;
        end else begin
            corrDone <= 1'b0;
            if (start) begin
                accReg  <= '0;
                cntReg  <= '0;
                busyReg <= 1'b1;
            end else if (busyReg && symTick) begin
                accReg <= accNext;
                cntReg <= cntReg + 1'b1;
                if (cntReg == CNT_W'(SYMBOLS - 1)) begin
                    busyReg  <= 1'b0;
                    corrAvg  <= 7'(accNext >> SHIFT);
                    corrDone <= 1'b1;
                end
            end
        end
    end
endmodule : rcc_corr_avg

// file: rtl/rcc_top.sv
// signal level, clear channel, synthesizer and power control block
//
// Overview of operation
// - signal level reads as eight-bit signed two's complement value
// - signal level is the mean of the latest eight symbol periods
// - level valid flag rises after eight enabled receive symbols
// - per packet, unsigned 7-bit mean correlation over first eight symbols
// - with append enabled, correlation, level and CRC flag follow frames
// - clear channel result counts only after eight enabled symbols
// - measured level is compared with a threshold in 1 dB steps
// - programmable hysteresis widens the threshold comparison
// - mode 1 energy, 2 no valid data, 3 both, 0 reserved
// - clear channel pin active high, inverted by polarity bit
// - transmit-if-clear strobe starts sending only on a clear channel
// - carrier MHz equals 2048 plus ten-bit channel word
// - oscillator sits 2 MHz below carrier in receive, on it in transmit
// - calibration runs on every receive or transmit enable
// - amplifier level is the low field of transmit control register
`timescale 1ns/1ps
`include "rcc_map.svh"
module rcc_top import rcc_pkg::*; #(
    parameter int CAL_CYCLES =
        (`RCC_CAL_NS + `RCC_CLK_PERIOD_NS - 1) / `RCC_CLK_PERIOD_NS,
    parameter int SYM_CYCLES = `RCC_SYMBOL_NS / `RCC_CLK_PERIOD_NS,
    parameter int AVG_SYMBOLS = `RCC_AVG_SYMBOLS
) (
    // clock and reset
    input  wire logic                   mclk,
    input  wire logic                   reset_n,
    // register bus
    input  wire logic [`RCC_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [`RCC_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    // receive path
    input  wire rcc_rx_in_t             rxIn,
    // radio control
    output logic                        rxOn,
    output logic                        txOn,
    output logic                        calOn,
    output logic [11:0]                 loFreqMhz,
    output logic [4:0]                  amplifierLevel,
    output logic                        clearChannelPin,
    // appended frame status
    output logic                        appendValid,
    output rcc_append_t                 appendWord
);
    if (CAL_CYCLES < 1 || SYM_CYCLES < 2) begin : g_chk
        $error("rcc_top: cycle counts too small");
    end

    localparam int CAL_W = $clog2(CAL_CYCLES + 1);
    localparam int SYM_W = $clog2(SYM_CYCLES);

    function automatic logic regMapped(input logic [`RCC_ADDR_W-1:0] a);
        return a == `RCC_OFS_CTRL || a == `RCC_OFS_MODEM ||
               a == `RCC_OFS_LEVEL || a == `RCC_OFS_SYNTH ||
               a == `RCC_OFS_TRANSMIT_CONTROL_REG || a == `RCC_OFS_PINCFG ||
               a == `RCC_OFS_STATUS || a == `RCC_OFS_CORR;
    endfunction : regMapped

    function automatic logic [31:0] byteMerge(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0]  strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = data[8*b +: 8];
            end
        end
        return r;
    endfunction : byteMerge

    // bus holding registers
    logic [`RCC_ADDR_W-1:0] awAddrReg;
    logic [31:0]            wDataReg;
    logic [3:0]             wStrbReg;
    logic                   doWrite;
    // software registers
    logic [7:0]             modemReg;
    logic [7:0]             thrReg;
    logic [9:0]             chanReg;
    logic [15:0]            txCtrlReg;
    logic                   polarityReg;
    // strobes
    logic                   ctrlWrite;
    logic                   strobeRx;
    logic                   strobeTx;
    logic                   strobeTxClear;
    logic                   strobeOff;
    // radio state
    rcc_state_t             stateReg;
    rcc_state_t             stateNext;
    logic [CAL_W-1:0]       calCountReg;
    logic                   calDone;
    logic [SYM_W-1:0]       symCountReg;
    logic                   symTick;
    logic                   rxEnabled;
    logic signed [7:0]      levelAvg;
    logic                   levelValid;
    logic [6:0]             corrAvg;
    logic                   energyBusyReg;
    logic signed [8:0]      thrLow;
    logic                   clearNow;
    logic                   ccaResult;

    assign doWrite = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign ctrlWrite = doWrite && awAddrReg == `RCC_OFS_CTRL && wStrbReg[0];
    assign strobeRx      = ctrlWrite && wDataReg[`RCC_CTRL_RX];
    assign strobeTx      = ctrlWrite && wDataReg[`RCC_CTRL_TX];
    assign strobeTxClear = ctrlWrite && wDataReg[`RCC_CTRL_TXCLEAR];
    assign strobeOff     = ctrlWrite && wDataReg[`RCC_CTRL_OFF];

    // write address, write data and response
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RCC_RESP_OKAY;
            awAddrReg     <= '0;
            wDataReg      <= 32'h0000_0000;
            wStrbReg      <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awAddrReg     <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wDataReg     <= s_axi_wdata;
                wStrbReg     <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (doWrite) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= regMapped(awAddrReg) ? `RCC_RESP_OKAY
                                                     : `RCC_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // configuration registers
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            modemReg    <= `RCC_RST_MODEM;
            thrReg      <= `RCC_RST_THR;
            chanReg     <= `RCC_RST_CHAN;
            txCtrlReg   <= `RCC_RST_TRANSMIT_CONTROL_REG;
            polarityReg <= 1'b0;
        end else if (doWrite) begin
            unique case (awAddrReg)
                `RCC_OFS_MODEM:  modemReg <= 8'(byteMerge(
                                     32'(modemReg), wDataReg, wStrbReg));
                `RCC_OFS_LEVEL:  thrReg <= 8'(byteMerge(
                                     32'(thrReg) << 8, wDataReg,
                                     wStrbReg) >> 8);
                `RCC_OFS_SYNTH:  chanReg <= 10'(byteMerge(
                                     32'(chanReg), wDataReg, wStrbReg));
                `RCC_OFS_TRANSMIT_CONTROL_REG: txCtrlReg <= 16'(byteMerge(
                                     32'(txCtrlReg), wDataReg, wStrbReg));
                `RCC_OFS_PINCFG: polarityReg <= 1'(byteMerge(
                                     32'(polarityReg), wDataReg, wStrbReg));
                default: ;
            endcase
        end
    end

    // read channel
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `RCC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= regMapped(s_axi_araddr) ? `RCC_RESP_OKAY
                                                     : `RCC_RESP_SLVERR;
            s_axi_rdata   <= 32'h0000_0000;
            unique case (s_axi_araddr)
                `RCC_OFS_MODEM:  s_axi_rdata <= 32'(modemReg);
                `RCC_OFS_LEVEL:  s_axi_rdata <= {16'h0000, thrReg,
                                                 levelAvg};
                `RCC_OFS_SYNTH:  s_axi_rdata <= 32'(chanReg);
                `RCC_OFS_TRANSMIT_CONTROL_REG: s_axi_rdata <= 32'(txCtrlReg);
                `RCC_OFS_PINCFG: s_axi_rdata <= 32'(polarityReg);
                `RCC_OFS_STATUS: begin
                    s_axi_rdata[`RCC_ST_LVALID] <= levelValid;
                    s_axi_rdata[`RCC_ST_TXACT]  <= txOn;
                    s_axi_rdata[`RCC_ST_CAL]    <= calOn;
                    s_axi_rdata[`RCC_ST_CCA]    <= ccaResult;
                    s_axi_rdata[`RCC_ST_RXON]   <= rxOn;
                end
                `RCC_OFS_CORR:   s_axi_rdata <= 32'(corrAvg);
                default: ;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // radio control state machine
    assign calDone = calCountReg == CAL_W'(CAL_CYCLES - 1);

    always_comb begin
        stateNext = stateReg;
        unique case (stateReg)
            RCC_IDLE: begin
                if (strobeTx) begin
                    stateNext = RCC_TX_CAL;
                end else if (strobeRx) begin
                    stateNext = RCC_RX_CAL;
                end
            end
            RCC_RX_CAL: begin
                if (calDone) begin
                    stateNext = RCC_RX;
                end
            end
            RCC_RX: begin
                if (strobeTx || (strobeTxClear && ccaResult)) begin
                    stateNext = RCC_TX_CAL;
                end else if (rxIn.ackRequest) begin
                    stateNext = RCC_ACK_CAL;
                end
            end
            RCC_TX_CAL, RCC_ACK_CAL: begin
                if (calDone) begin
                    stateNext = RCC_TX;
                end
            end
            RCC_TX: begin
                if (rxIn.txDone) begin
                    stateNext = RCC_RX_CAL;
                end
            end
        endcase
        if (strobeOff) begin
            stateNext = RCC_IDLE;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            stateReg <= RCC_IDLE;
        end else begin
            stateReg <= stateNext;
        end
    end

    // calibration timer restarts on each calibration entry
    always_ff @(posedge mclk) begin
        if (!reset_n || stateNext != stateReg) begin
            calCountReg <= '0;
        end else if (calOn && !calDone) begin
            calCountReg <= calCountReg + 1'b1;
        end
    end

    // radio enables
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            rxOn  <= 1'b0;
            txOn  <= 1'b0;
            calOn <= 1'b0;
        end else begin
            rxOn  <= stateNext == RCC_RX_CAL || stateNext == RCC_RX;
            txOn  <= stateNext == RCC_TX_CAL || stateNext == RCC_ACK_CAL ||
                     stateNext == RCC_TX;
            calOn <= stateNext == RCC_RX_CAL || stateNext == RCC_TX_CAL ||
                     stateNext == RCC_ACK_CAL;
        end
    end

    // symbol timing, running only while receiving
    assign rxEnabled = stateReg == RCC_RX;
    assign symTick   = rxEnabled && symCountReg == SYM_W'(SYM_CYCLES - 1);

    always_ff @(posedge mclk) begin
        if (!reset_n || !rxEnabled || symTick) begin
            symCountReg <= '0;
        end else begin
            symCountReg <= symCountReg + 1'b1;
        end
    end

    rcc_level_avg #(
        .DEPTH      (AVG_SYMBOLS)
    ) u_level (
        .mclk       (mclk),
        .reset_n    (reset_n),
        .enable     (rxEnabled),
        .symTick    (symTick),
        .sampleIn   (rxIn.level),
        .levelAvg   (levelAvg),
        .levelValid (levelValid)
    );

    rcc_corr_avg #(
        .SYMBOLS  (AVG_SYMBOLS)
    ) u_corr (
        .mclk     (mclk),
        .reset_n  (reset_n),
        .start    (rxIn.sfdSeen && rxEnabled),
        .symTick  (symTick),
        .corrIn   (rxIn.corr),
        .corrAvg  (corrAvg),
        .corrDone ()
    );

    // energy detect with hysteresis
    assign thrLow = $signed({thrReg[7], thrReg}) -
        $signed({6'h00, modemReg[`RCC_MODEM_HYST_LO +: 3]});

    always_ff @(posedge mclk) begin
        if (!reset_n || !levelValid) begin
            energyBusyReg <= 1'b0;
        end else if (!energyBusyReg && levelAvg >= $signed(thrReg)) begin
            energyBusyReg <= 1'b1;
        end else if (energyBusyReg && $signed({levelAvg[7], levelAvg})
                     < thrLow) begin
            energyBusyReg <= 1'b0;
        end
    end

    always_comb begin
        unique case (modemReg[`RCC_MODEM_MODE_LO +: 2])
            2'h0: clearNow = 1'b0;
            2'h1: clearNow = !energyBusyReg;
            2'h2: clearNow = !rxIn.frameActive;
            2'h3: clearNow = !energyBusyReg && !rxIn.frameActive;
        endcase
    end

    assign ccaResult = levelValid && clearNow;

    // pin, synthesizer and amplifier outputs
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            clearChannelPin <= 1'b0;
            loFreqMhz       <= `RCC_CARRIER_BASE;
            amplifierLevel  <= 5'h00;
        end else begin
            clearChannelPin <= ccaResult ^ polarityReg;
            loFreqMhz <= `RCC_CARRIER_BASE + 12'(chanReg)
                - ((stateNext == RCC_RX_CAL || stateNext == RCC_RX)
                   ? `RCC_IF_OFFSET : 12'h000);
            amplifierLevel  <= txCtrlReg[4:0];
        end
    end

    // status appended at frame end
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            appendValid <= 1'b0;
            appendWord  <= '0;
        end else begin
            appendValid <= rxIn.frameEnd && modemReg[`RCC_MODEM_APPEND];
            if (rxIn.frameEnd && modemReg[`RCC_MODEM_APPEND]) begin
                appendWord <= '{corr: corrAvg, level: levelAvg,
                                crcOk: rxIn.crcOk};
            end
        end
    end
endmodule : rcc_top

// file: sim/rcc_radio_model.sv
// receive front end model feeding samples and frame events
`timescale 1ns/1ps
module rcc_radio_model import rcc_pkg::*; (
    // clock
    input wire logic mclk,
    // receive samples
    output rcc_rx_in_t rxIn
);
    initial rxIn = '{level: 8'hec, corr: 7'h6e, default: '0};
    task automatic sendFrame();
        @(posedge mclk);
        rxIn.sfdSeen <= 1'b1;
        rxIn.frameActive <= 1'b1;
        @(posedge mclk);
        rxIn.sfdSeen <= 1'b0;
        repeat (40) @(posedge mclk);
        rxIn.frameEnd <= 1'b1;
        rxIn.crcOk <= 1'b1;
        @(posedge mclk);
        rxIn.frameEnd <= 1'b0;
        rxIn.crcOk <= 1'b0;
        rxIn.frameActive <= 1'b0;
    endtask : sendFrame
    task automatic endTx();
        @(posedge mclk);
        rxIn.txDone <= 1'b1;
        @(posedge mclk);
        rxIn.txDone <= 1'b0;
    endtask : endTx
endmodule : rcc_radio_model

// file: sim/rcc_top_sva.sv
// assertions on the rcc top ports
`timescale 1ns/1ps
module rcc_top_sva import rcc_pkg::*; #(
    parameter int CAL_CYCLES = 4
) (
    // clock and reset
    input wire logic        mclk,
    input wire logic        reset_n,
    // read channel
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // radio
    input wire rcc_rx_in_t  rxIn,
    input wire logic        rxOn,
    input wire logic        txOn,
    input wire logic        calOn,
    input wire logic [11:0] loFreqMhz,
    input wire logic        appendValid
);
    int calCnt;
    always_ff @(posedge mclk) calCnt <= calOn ? calCnt + 1 : 0;
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    rx_lo_a: assert property ($rose(txOn) && $past(rxOn) |->
        loFreqMhz == $past(loFreqMhz) + 12'h002) else $error("lo offset");
    cal_rx_a: assert property ($rose(rxOn) |-> calOn)
        else $error("rx without calibration");
    cal_tx_a: assert property ($rose(txOn) |-> calOn)
        else $error("tx without calibration");
    cal_len_a: assert property (calOn |-> calCnt <= CAL_CYCLES)
        else $error("calibration too long");
    ap_pulse_a: assert property (appendValid |=> !appendValid)
        else $error("append pulse too long");
    ap_cause_a: assert property (appendValid |-> $past(rxIn.frameEnd))
        else $error("append without frame end");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read dropped");
    mode_excl_a: assert property (!(rxOn && txOn))
        else $error("rx and tx together");
    cover property (appendValid);
    cover property ($rose(txOn));
    cover property ($rose(rxOn));
endmodule : rcc_top_sva
bind rcc_top rcc_top_sva #(.CAL_CYCLES(CAL_CYCLES)) u_sva (.mclk, .reset_n,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .rxIn, .rxOn, .txOn, .calOn,
    .loFreqMhz, .appendValid);

// file: sim/rcc_top_bench.sv
// self-checking bench for the rcc block
`timescale 1ns/1ps
`include "rcc_map.svh"
module rcc_top_bench import rcc_pkg::*;;
    logic mclk = 0, reset_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
    logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, rxOn, txOn, calOn, clearChannelPin, appendValid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic [11:0] loFreqMhz, fc;
    logic [4:0] amplifierLevel;
    logic [7:0] thr[3] = '{8'hec, 8'hf0, 8'hf2};
    logic clr[3] = '{1'b0, 1'b0, 1'b1};
    rcc_rx_in_t rxIn;
    rcc_append_t appendWord;
    int n_errors = 0, checks = 0, cyc = 0;
    rcc_top #(.CAL_CYCLES(4), .SYM_CYCLES(4)) u_dut (.*);
    rcc_radio_model u_radio (.mclk, .rxIn);
    always #12.5 mclk = ~mclk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: %h vs %h", $time, seen, exp);
        end
    endtask : chk
    task automatic final_report();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : final_report
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask : wr
    task automatic rdReg(input logic [7:0] a);
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        forever begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) break;
            if (s_axi_rvalid) s_axi_rready <= 1'b1;
        end
        rd = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rdReg
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            final_report();
        end
    end
    initial begin
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        rdReg(`RCC_OFS_LEVEL);
        chk(rd[15:8], 8'he0);
        rdReg(`RCC_OFS_TRANSMIT_CONTROL_REG);
        chk(rd, 32'ha0ff);
        chk(amplifierLevel, 5'h1f);
        rdReg(8'h20);
        chk(rr, `RCC_RESP_SLVERR);
        for (int k = 11; k <= 26; k++) begin
            wr(`RCC_OFS_SYNTH, 32'(357 + 5 * (k - 11)));
            fc = 12'h800 + 12'(357 + 5 * (k - 11));
            chk(loFreqMhz, fc);
        end
        wr(`RCC_OFS_TRANSMIT_CONTROL_REG, 32'ha0e3);
        chk(amplifierLevel, 5'h03);
        wr(`RCC_OFS_CTRL, 32'h1);
        repeat (50) @(posedge mclk);
        chk(loFreqMhz, fc - 12'h002);
        rdReg(`RCC_OFS_STATUS);
        chk(rd[0], 1'b1);
        rdReg(`RCC_OFS_LEVEL);
        chk(rd[7:0], 8'hec);
        wr(`RCC_OFS_CTRL, 32'h4);
        chk(txOn, 1'b0);
        wr(`RCC_OFS_LEVEL, 32'h1000);
        for (int m = 0; m < 4; m++) begin
            wr(`RCC_OFS_MODEM, 32'h29 | 32'(m << 1));
            chk(clearChannelPin, m != 0);
        end
        wr(`RCC_OFS_PINCFG, 32'h1);
        chk(clearChannelPin, 1'b0);
        for (int i = 0; i < 3; i++) begin
            wr(`RCC_OFS_LEVEL, {16'h0, thr[i], 8'h0});
            rdReg(`RCC_OFS_STATUS);
            chk(rd[3], clr[i]);
        end
        u_radio.sendFrame();
        for (int i = 0; i < 4 && appendValid !== 1'b1; i++) @(posedge mclk);
        chk(appendWord, {7'h6e, 8'hec, 1'b1});
        rdReg(`RCC_OFS_CORR);
        chk(rd, 32'h6e);
        wr(`RCC_OFS_CTRL, 32'h4);
        chk(txOn, 1'b1);
        chk(loFreqMhz, fc);
        u_radio.endTx();
        repeat (2) @(posedge mclk);
        chk(rxOn, 1'b1);
        chk(calOn, 1'b1);
        wr(`RCC_OFS_CTRL, 32'h8);
        wr(`RCC_OFS_CTRL, 32'h1);
        repeat (12) @(posedge mclk);
        rdReg(`RCC_OFS_LEVEL);
        chk(rd[7:0], 8'hf8);
        rdReg(`RCC_OFS_STATUS);
        chk(rd[0], 1'b0);
        chk(rd[3], 1'b0);
        reset_n <= 1'b0;
        repeat (3) @(posedge mclk);
        reset_n <= 1'b1;
        rdReg(`RCC_OFS_SYNTH);
        chk(rd, 32'h165);
        chk(rxOn, 1'b0);
        final_report();
    end
endmodule : rcc_top_bench
